// ===== rtl/uart_dp_baud.sv
// Baud tick generator: one tick per 1/16 bit time.
// Assumes the divisor is stable between writes; a zero divisor stops ticks.
`default_nettype none
module uart_dp_baud (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Divisor
  input wire logic [15:0] i_divisor,
  // Tick
  output logic o_tick,
  output logic o_running
);
  import uart_dp_pkg::*;
  logic [15:0] cnt_ff;
  logic tick_ff;
  wire div_zero = (i_divisor == 16'h0000);
  wire at_end = (cnt_ff >= i_divisor - 16'h0001);
  assign o_tick = tick_ff;
  assign o_running = !div_zero;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_zero) begin // RL15
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= at_end ? 16'h0000 : cnt_ff + 16'h0001; // RL14
      tick_ff <= at_end;
    end
  end
endmodule : uart_dp_baud
`default_nettype wire

// ===== rtl/uart_dp_fifo.sv
// Byte FIFO used for both receive and transmit paths.
// Assumes nothing of the caller: a push when full or a pop when empty is ignored.
`default_nettype none
module uart_dp_fifo #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_clear,
  input wire logic i_push,
  input wire logic [7:0] i_data,
  input wire logic i_pop,
  // Status
  output logic [7:0] o_head,
  output logic o_empty,
  output logic o_full
);
  import uart_dp_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end
  logic [7:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  wire do_push = i_push && !o_full;
  wire do_pop = i_pop && !o_empty;
  assign o_empty = (wr_ff == rd_ff);
  assign o_full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
  assign o_head = mem_ff[rd_ff[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (do_push) mem_ff[wr_ff[AW-1:0]] <= i_data;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else if (i_clear) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (do_push) wr_ff <= wr_ff + 1'b1;
      if (do_pop) rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule : uart_dp_fifo
`default_nettype wire

// ===== rtl/uart_dp_pkg.sv
// Constants and types shared by the data/divisor port UART block.
// Assumes a single 20 MHz system clock and an APB slave with 32-bit data.
`default_nettype none
package uart_dp_pkg;
  // ==========================================================================
  // Register map (byte addresses on APB)
  localparam logic [31:0] ADDR_DATA_DIVLO = 32'h5000_1000;
  localparam logic [31:0] ADDR_IRQEN_DIVHI = 32'h5000_1004;
  localparam logic [31:0] ADDR_LINE_CTRL = 32'h5000_100c;
  localparam logic [31:0] ADDR_LINE_STAT = 32'h5000_1014;
  localparam logic [31:0] ADDR_FIFO_CTRL = 32'h5000_1008;
  localparam logic [31:0] ADDR_MODE_CTRL = 32'h5000_1024;
  // ==========================================================================
  // Field positions
  localparam int LCR_DIV_ACCESS_BIT = 7;
  localparam int FCR_FIFO_EN_BIT = 0;
  localparam int LSR_DATA_READY_BIT = 0;
  localparam int LSR_OVERRUN_BIT = 1;
  localparam int LSR_THR_EMPTY_BIT = 5;
  localparam int LSR_TX_IDLE_BIT = 6;
  localparam int IER_LINE_STAT_BIT = 2;
  localparam int IER_TX_EMPTY_BIT = 1;
  localparam int IER_PROG_TX_EMPTY_BIT = 7;
  localparam int MODE_INFRARED_BIT = 0;
  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int FIFO_DEPTH_DEFAULT = 16;
  localparam int OVERSAMPLE = 16;
  localparam int BITS_PER_FRAME = 10;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } byte_beat_t;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_STOP
  } ser_state_t;
endpackage : uart_dp_pkg
`default_nettype wire

// ===== rtl/uart_dp_top.sv
// UART data and divisor port: receive buffer / FIFO, transmit holding /
// FIFO, divisor latch and interrupt-enable bits, reached over APB.
// Assumes the serial clock equals the system clock and pins are synchronous.
//
// Notes on behaviour
// (RL1) Received serial bytes go into receive buffer
// (RL2) Infrared mode receives from infrared input pin
// (RL3) Receive data valid only while data-ready set
// (RL4) No FIFO: new byte overwrites, flags overrun
// (RL5) FIFO mode: reads return receive FIFO head
// (RL6) Full receive FIFO: drop new byte, overrun
// (RL7) Written bytes serialised onto serial output
// (RL8) Infrared mode transmits on active-low output
// (RL9) Software writes only while holding-empty flag set
// (RL10) No FIFO: one write clears holding-empty flag
// (RL11) Transmit FIFO sixteen deep, full writes dropped
// (RL12) Divisor low byte: lower eight bits, read/write
// (RL13) Divisor bytes reachable only with access bit
// (RL14) Baud equals clock over sixteen times divisor
// (RL15) Zero divisor stops baud clock and transfers
// (RL16) Software waits eight cycles after divisor write
// (RL17) Enable bit 7: programmable empty-interrupt mode
// (RL18) With access bit, bit 7 is divisor bit
// (RL19) Enable bit 2: line status interrupt
// (RL20) Enable bit 1: holding-empty interrupt
// (RL21) FIFO read pops head entry
// (RL22) Bits 15..8 read zero, ignore writes
//
// The APB register port was left to the implementer.
`default_nettype none
module uart_dp_top #(
  parameter int FIFO_DEPTH = uart_dp_pkg::FIFO_DEPTH_DEFAULT
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Serial pins
  input wire logic I_SERIAL_IN,
  input wire logic I_IR_IN,
  output logic O_SERIAL_OUT,
  output logic O_IR_OUT_N,
  // Interrupt enables toward the remaining interrupt logic
  output logic O_LINE_STATUS_IRQ_EN,
  output logic O_TX_EMPTY_IRQ_EN,
  output logic O_PROG_TX_EMPTY_IRQ_MODE
);
  import uart_dp_pkg::*;

  // ==========================================================================
  // APB decode
  apb_req_t req;
  assign req = '{sel: I_PSEL, en: I_PENABLE, wr: I_PWRITE, addr: I_PADDR, wdata: I_PWDATA};
  wire access = req.sel && req.en;
  wire hit_data = (req.addr == ADDR_DATA_DIVLO);
  wire hit_ier = (req.addr == ADDR_IRQEN_DIVHI);
  wire hit_lcr = (req.addr == ADDR_LINE_CTRL);
  wire hit_fcr = (req.addr == ADDR_FIFO_CTRL);
  wire hit_lsr = (req.addr == ADDR_LINE_STAT);
  wire hit_mode = (req.addr == ADDR_MODE_CTRL);
  wire mapped = hit_data || hit_ier || hit_lcr || hit_fcr || hit_lsr || hit_mode;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access && !mapped;

  // ==========================================================================
  // Control registers
  logic [7:0] div_lo_ff;
  logic [7:0] div_hi_ff;
  logic [7:0] ier_ff;
  logic [7:0] lcr_ff;
  logic fifo_en_ff;
  logic ir_mode_ff;
  logic overrun_ff;
  logic hold_full_ff;
  logic [7:0] hold_ff;
  logic [7:0] rbuf_ff;
  logic rbuf_valid_ff;
  logic [31:0] prdata_ff;

  wire div_access = lcr_ff[LCR_DIV_ACCESS_BIT];
  wire wr_data = access && req.wr && hit_data && !div_access;
  wire rd_data = access && !req.wr && hit_data && !div_access;
  wire wr_div_lo = access && req.wr && hit_data && div_access; // RL13
  wire wr_div_hi = access && req.wr && hit_ier && div_access; // RL18
  wire wr_ier = access && req.wr && hit_ier && !div_access;
  wire wr_lcr = access && req.wr && hit_lcr;
  wire wr_fcr = access && req.wr && hit_fcr;
  wire wr_mode = access && req.wr && hit_mode;
  wire rd_lsr = access && !req.wr && hit_lsr;
  wire fifo_en_new = req.wdata[FCR_FIFO_EN_BIT];
  wire fifo_mode_change = wr_fcr && (fifo_en_new != fifo_en_ff);

  assign O_LINE_STATUS_IRQ_EN = ier_ff[IER_LINE_STAT_BIT]; // RL19
  assign O_TX_EMPTY_IRQ_EN = ier_ff[IER_TX_EMPTY_BIT]; // RL20
  assign O_PROG_TX_EMPTY_IRQ_MODE = ier_ff[IER_PROG_TX_EMPTY_BIT]; // RL17

  // ==========================================================================
  // Baud ticks
  logic tick;
  logic baud_on;
  uart_dp_baud u_baud (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_divisor({div_hi_ff, div_lo_ff}),
    .o_tick(tick),
    .o_running(baud_on)
  );

  // ==========================================================================
  // FIFOs
  logic [7:0] rx_head;
  logic rx_empty;
  logic rx_full;
  logic [7:0] tx_head;
  logic tx_empty;
  logic tx_full;
  logic rx_done;
  logic [7:0] rx_byte;
  logic tx_take;
  wire rx_push = rx_done && fifo_en_ff && !rx_full; // RL6
  wire rx_pop = rd_data && fifo_en_ff; // RL21
  wire tx_push = wr_data && fifo_en_ff && !tx_full; // RL11
  wire tx_pop = tx_take && fifo_en_ff;
  uart_dp_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_clear(fifo_mode_change),
    .i_push(rx_push),
    .i_data(rx_byte),
    .i_pop(rx_pop),
    .o_head(rx_head),
    .o_empty(rx_empty),
    .o_full(rx_full)
  );
  uart_dp_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_clear(fifo_mode_change),
    .i_push(tx_push),
    .i_data(req.wdata[7:0]),
    .i_pop(tx_pop),
    .o_head(tx_head),
    .o_empty(tx_empty),
    .o_full(tx_full)
  );

  // ==========================================================================
  // Status
  wire data_ready = fifo_en_ff ? !rx_empty : rbuf_valid_ff; // RL3
  wire thr_empty = fifo_en_ff ? tx_empty : !hold_full_ff;
  wire tx_has = fifo_en_ff ? !tx_empty : hold_full_ff;
  wire [7:0] tx_next = fifo_en_ff ? tx_head : hold_ff;
  wire rx_overrun = rx_done && (fifo_en_ff ? rx_full : rbuf_valid_ff); // RL4 RL6
  logic tx_idle;
  wire [7:0] lsr_val = {1'b0, tx_idle && !tx_has, thr_empty, 3'b000, overrun_ff, data_ready};

  // ==========================================================================
  // Read mux, bits above a byte read zero
  wire [7:0] data_rd = div_access ? div_lo_ff : (fifo_en_ff ? rx_head : rbuf_ff); // RL5 RL12
  wire [7:0] rd_byte =
    hit_data ? data_rd :
    hit_ier ? (div_access ? div_hi_ff : ier_ff) :
    hit_lcr ? lcr_ff :
    hit_lsr ? lsr_val :
    hit_mode ? {7'b0000000, ir_mode_ff} : 8'h00;
  // Captured in the setup cycle, so read data comes from a flop and
  // stands through the zero-wait access phase
  wire setup_phase = req.sel && !req.en;
  assign O_PRDATA = prdata_ff;
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_ff <= {24'h000000, rd_byte}; // RL22
    end
  end

  // ==========================================================================
  // Register writes
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      div_lo_ff <= RESET_BYTE;
      div_hi_ff <= RESET_BYTE;
      ier_ff <= RESET_BYTE;
      lcr_ff <= RESET_BYTE;
      fifo_en_ff <= 1'b0;
      ir_mode_ff <= 1'b0;
    end else begin
      if (wr_div_lo) div_lo_ff <= req.wdata[7:0]; // RL12
      if (wr_div_hi) div_hi_ff <= req.wdata[7:0]; // RL18
      if (wr_ier) ier_ff <= {req.wdata[7], 4'h0, req.wdata[2:0]}; // RL17 RL22
      if (wr_lcr) lcr_ff <= req.wdata[7:0];
      if (wr_fcr) fifo_en_ff <= fifo_en_new;
      if (wr_mode) ir_mode_ff <= req.wdata[MODE_INFRARED_BIT];
    end
  end

  // Non-FIFO buffers and overrun; a new event wins over the read clear
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rbuf_ff <= RESET_BYTE;
      rbuf_valid_ff <= 1'b0;
      hold_ff <= RESET_BYTE;
      hold_full_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      if (rx_done && !fifo_en_ff) begin
        rbuf_ff <= rx_byte; // RL1 RL4
        rbuf_valid_ff <= 1'b1;
      end else if (rd_data || fifo_mode_change) begin
        rbuf_valid_ff <= 1'b0;
      end
      if (wr_data && !fifo_en_ff) begin
        hold_ff <= req.wdata[7:0];
        hold_full_ff <= 1'b1; // RL10
      end else if ((tx_take && !fifo_en_ff) || fifo_mode_change) begin
        hold_full_ff <= 1'b0;
      end
      if (rx_overrun) overrun_ff <= 1'b1; // RL4 RL6
      // Clear only what the read showed; a later overrun is kept
      else if (rd_lsr && prdata_ff[LSR_OVERRUN_BIT]) overrun_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Receiver: 16x oversampling, mid-bit sampling except in infrared mode
  wire rx_pin = ir_mode_ff ? !I_IR_IN : I_SERIAL_IN; // RL2
  ser_state_t rx_st_ff;
  logic [3:0] rx_os_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_done_ff;
  assign rx_done = rx_done_ff;
  assign rx_byte = rx_sh_ff;
  // Infrared zeros are short pulses and timing locks to the pulse start,
  // so sample two ticks in rather than at mid-bit
  wire [3:0] rx_sample_os = ir_mode_ff ? 4'h1 : 4'h7; // RL2
  wire rx_mid = tick && (rx_os_ff == rx_sample_os);
  wire rx_last = tick && (rx_os_ff == 4'hf);
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_st_ff <= SER_IDLE;
      rx_os_ff <= 4'h0;
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= RESET_BYTE;
      rx_done_ff <= 1'b0;
    end else begin
      rx_done_ff <= 1'b0;
      if (!baud_on) begin // RL15
        rx_st_ff <= SER_IDLE;
        rx_os_ff <= 4'h0;
      end else if (tick) begin
        rx_os_ff <= rx_os_ff + 4'h1;
        unique case (rx_st_ff)
          SER_IDLE: begin
            rx_os_ff <= 4'h0;
            if (!rx_pin) rx_st_ff <= SER_START;
          end
          SER_START: begin
            if (rx_mid && rx_pin) rx_st_ff <= SER_IDLE;
            if (rx_last) rx_st_ff <= SER_DATA;
          end
          SER_DATA: begin
            if (rx_mid) rx_sh_ff <= {rx_pin, rx_sh_ff[7:1]};
            if (rx_last) begin
              rx_bit_ff <= rx_bit_ff + 3'h1;
              if (rx_bit_ff == 3'h7) rx_st_ff <= SER_STOP;
            end
          end
          SER_STOP: begin
            if (rx_mid) begin
              rx_done_ff <= 1'b1; // RL1
              rx_st_ff <= SER_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Transmitter
  ser_state_t tx_st_ff;
  logic [3:0] tx_os_ff;
  logic [2:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic tx_line_ff;
  assign tx_take = baud_on && tick && (tx_st_ff == SER_IDLE) && tx_has;
  assign tx_idle = (tx_st_ff == SER_IDLE);
  assign O_SERIAL_OUT = ir_mode_ff ? 1'b1 : tx_line_ff; // RL7
  wire ir_pulse = ir_mode_ff && !tx_line_ff && (tx_os_ff[3:2] == 2'b01);
  assign O_IR_OUT_N = !ir_pulse; // RL8
  wire tx_bit_end = tick && (tx_os_ff == 4'hf);
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_st_ff <= SER_IDLE;
      tx_os_ff <= 4'h0;
      tx_bit_ff <= 3'h0;
      tx_sh_ff <= RESET_BYTE;
      tx_line_ff <= 1'b1;
    end else if (!baud_on) begin // RL15
      tx_st_ff <= SER_IDLE;
      tx_os_ff <= 4'h0;
      tx_line_ff <= 1'b1;
    end else if (tick) begin
      tx_os_ff <= tx_os_ff + 4'h1;
      unique case (tx_st_ff)
        SER_IDLE: begin
          tx_os_ff <= 4'h0;
          if (tx_take) begin
            tx_sh_ff <= tx_next; // RL7
            tx_line_ff <= 1'b0;
            tx_st_ff <= SER_START;
          end
        end
        SER_START: begin
          if (tx_bit_end) begin
            tx_line_ff <= tx_sh_ff[0];
            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            tx_bit_ff <= 3'h0;
            tx_st_ff <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (tx_bit_end) begin
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (tx_bit_ff == 3'h7) begin
              tx_line_ff <= 1'b1;
              tx_st_ff <= SER_STOP;
            end else begin
              tx_line_ff <= tx_sh_ff[0];
              tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            end
          end
        end
        SER_STOP: begin
          if (tx_bit_end) tx_st_ff <= SER_IDLE;
        end
      endcase
    end
  end
endmodule : uart_dp_top
`default_nettype wire

// ===== testbench/uart_data_divisor_port_tb_top.sv
// Self-checking bench for the UART data/divisor port over APB.
// Assumes uart_dp_top, its package and the serial peer model.
`default_nettype none
module uart_data_divisor_port_tb_top import uart_dp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Divisor 2 gives 32 clocks a bit; receive and transmit FIFOs shortened to 4
  localparam int BITC = OVERSAMPLE * 2;
  localparam int FRAME = BITC * BITS_PER_FRAME;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0;
  logic [31:0] prdata, r;
  logic ready, slverr, ser_in, ir_in, ser_out, ir_out_n, en_line, en_tx, en_prog, last_err;
  int num_errors = 0;
  int check_count = 0;
  uart_dp_top #(.FIFO_DEPTH(4)) dut (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(ready), .O_PSLVERR(slverr), .I_SERIAL_IN(ser_in), .I_IR_IN(ir_in),
    .O_SERIAL_OUT(ser_out), .O_IR_OUT_N(ir_out_n), .O_LINE_STATUS_IRQ_EN(en_line),
    .O_TX_EMPTY_IRQ_EN(en_tx), .O_PROG_TX_EMPTY_IRQ_MODE(en_prog)
  );
  uart_dp_peer #(.BIT_CLKS(BITC)) peer (
    .i_clk(clk), .i_ser(ser_out), .i_ir_n(ir_out_n), .o_ser(ser_in), .o_ir(ir_in)
  );
  initial begin
    forever #25 clk = ~clk;
  end
  // ====
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (ready !== 1'b1);
    chk({31'h0, ready}, 32'h1);
    q = prdata;
    last_err = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, exp, input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask : rd
  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    conclude();
  end
  // ====
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_DATA_DIVLO, 32'h0);
    rd(ADDR_IRQEN_DIVHI, 32'h0);
    rd(ADDR_LINE_STAT, 32'h60);
    rd(32'h5000_1040, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    wr(ADDR_IRQEN_DIVHI, 32'hffff);
    rd(ADDR_IRQEN_DIVHI, 32'h87);
    chk({29'h0, en_prog, en_line, en_tx}, 32'h7);
    wr(ADDR_DATA_DIVLO, 32'h5a);
    rd(ADDR_LINE_STAT, 32'h0, 32'h21);
    repeat (2 * FRAME) @(posedge clk);
    chk(32'(peer.got.size()), 32'h0);
    wr(ADDR_LINE_CTRL, 32'h80);
    wr(ADDR_IRQEN_DIVHI, 32'ha5);
    rd(ADDR_IRQEN_DIVHI, 32'ha5);
    wr(ADDR_IRQEN_DIVHI, 32'h0);
    wr(ADDR_DATA_DIVLO, 32'h2);
    rd(ADDR_DATA_DIVLO, 32'h2);
    wr(ADDR_LINE_CTRL, 32'h0);
    rd(ADDR_IRQEN_DIVHI, 32'h87);
    repeat (8) @(posedge clk);
    repeat (2 * FRAME) @(posedge clk);
    chk({24'h0, peer.got[0]}, 32'h5a);
    rd(ADDR_LINE_STAT, 32'h20, 32'h20);
    peer.send(1'b0, 8'h3c);
    rd(ADDR_LINE_STAT, 32'h1, 32'h1);
    rd(ADDR_DATA_DIVLO, 32'h3c);
    rd(ADDR_LINE_STAT, 32'h0, 32'h1);
    peer.send(1'b0, 8'h11);
    peer.send(1'b0, 8'h22);
    rd(ADDR_LINE_STAT, 32'h3, 32'h3);
    rd(ADDR_DATA_DIVLO, 32'h22);
    wr(ADDR_MODE_CTRL, 32'h1);
    peer.send(1'b1, 8'hc3);
    rd(ADDR_DATA_DIVLO, 32'hc3);
    wr(ADDR_DATA_DIVLO, 32'h96);
    repeat (2 * FRAME) @(posedge clk);
    chk({24'h0, peer.got[1]}, 32'h96);
    wr(ADDR_MODE_CTRL, 32'h0);
    wr(ADDR_FIFO_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      peer.send(1'b0, 8'h10 + 8'(i));
    end
    rd(ADDR_LINE_STAT, 32'h3, 32'h3);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_DATA_DIVLO, 32'h10 + i);
    end
    rd(ADDR_LINE_STAT, 32'h0, 32'h1);
    // Sixth write lands on a full transmit FIFO
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_DATA_DIVLO, 32'h70 + i);
    end
    repeat (7 * FRAME) @(posedge clk);
    chk(32'(peer.got.size()), 32'h7);
    for (int i = 0; i < 5; i++) begin
      chk({24'h0, peer.got[2 + i]}, 32'h70 + i);
    end
    conclude();
  end
endmodule : uart_data_divisor_port_tb_top
`default_nettype wire

// ===== testbench/uart_dp_peer.sv
// Remote serial peer: sends frames, collects what the device sends.
// Assumes 8N1, LSB first, a fixed bit length in clocks.
`default_nettype none
module uart_dp_peer #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input wire logic i_clk,
  // Lines from the device
  input wire logic i_ser,
  input wire logic i_ir_n,
  // Lines to the device
  output logic o_ser,
  output logic o_ir
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial begin
    o_ser = 1'b1;
    o_ir = 1'b0;
  end
  // ====
  // Sender; an infrared zero is a pulse centred in its bit
  task automatic send(input logic ir, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < BIT_CLKS; k++) begin
        @(posedge i_clk);
        o_ser <= ir | f[i];
        o_ir <= ir & !f[i] & (k >= BIT_CLKS * 6 / 16) & (k < BIT_CLKS * 10 / 16);
      end
    end
  endtask : send
  // Serial receiver, sampling mid-bit
  always begin : ser_rx
    logic [7:0] b;
    @(negedge i_ser);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      b[i] = i_ser;
    end
    repeat (BIT_CLKS) @(posedge i_clk);
    got.push_back(b);
  end
  // Infrared receiver: windows straddle the pulses, any low is a zero
  always begin : ir_rx
    logic [7:0] b;
    @(negedge i_ir_n);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = 1'b1;
      repeat (BIT_CLKS) begin
        @(posedge i_clk);
        if (!i_ir_n) b[i] = 1'b0;
      end
    end
    got.push_back(b);
  end
endmodule : uart_dp_peer
`default_nettype wire

// ===== testbench/uart_dp_top_assertions.sv
// Checker for the APB data/divisor port of the UART.
// Bound to uart_dp_top; sees its ports only.
`default_nettype none
module uart_dp_top_assertions
  import uart_dp_pkg::*;
(
  // Clock, reset and APB
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PSLVERR,
  // Pins and enables
  input wire logic O_SERIAL_OUT,
  input wire logic O_IR_OUT_N,
  input wire logic O_LINE_STATUS_IRQ_EN,
  input wire logic O_TX_EMPTY_IRQ_EN,
  input wire logic O_PROG_TX_EMPTY_IRQ_MODE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc, wr_ev, rd_ev, mapped, divisor_access_bit_ff, ir_ff;
  logic [7:0] lo_ff, hi_ff, ier_ff;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  // ====
  // Shadow of what software has written
  assign acc = I_PSEL && I_PENABLE;
  assign wr_ev = acc && I_PWRITE;
  assign rd_ev = acc && !I_PWRITE;
  assign mapped = I_PADDR inside {ADDR_DATA_DIVLO, ADDR_IRQEN_DIVHI, ADDR_LINE_CTRL,
    ADDR_LINE_STAT, ADDR_FIFO_CTRL, ADDR_MODE_CTRL};
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      {divisor_access_bit_ff, ir_ff, lo_ff, hi_ff, ier_ff} <= '0;
    end else if (wr_ev) begin
      if (I_PADDR == ADDR_LINE_CTRL) divisor_access_bit_ff <= I_PWDATA[LCR_DIV_ACCESS_BIT];
      if (I_PADDR == ADDR_MODE_CTRL) ir_ff <= I_PWDATA[MODE_INFRARED_BIT];
      if (I_PADDR == ADDR_DATA_DIVLO && divisor_access_bit_ff) lo_ff <= I_PWDATA[7:0];
      if (I_PADDR == ADDR_IRQEN_DIVHI && divisor_access_bit_ff) hi_ff <= I_PWDATA[7:0];
      // Only bits 7 and 2:0 are kept
      if (I_PADDR == ADDR_IRQEN_DIVHI && !divisor_access_bit_ff) ier_ff <= I_PWDATA[7:0] & 8'h87;
    end
  end
  // ====
  // Properties
  sequence s_rd(logic [31:0] a, logic d);
    rd_ev && I_PADDR == a && divisor_access_bit_ff == d;
  endsequence
  property p_slverr;
    acc |-> O_PSLVERR == !mapped;
  endproperty
  a_slverr: assert property (p_slverr) else $error("slave error not per decode");
  property p_idle_ok;
    !acc |-> !O_PSLVERR;
  endproperty
  a_idle_ok: assert property (p_idle_ok) else $error("slave error outside access");
  property p_upper;
    rd_ev |-> O_PRDATA[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_div_lo;
    s_rd(ADDR_DATA_DIVLO, 1'b1) |-> O_PRDATA[7:0] == lo_ff;
  endproperty
  a_div_lo: assert property (p_div_lo) else $error("divisor low readback");
  property p_div_hi;
    s_rd(ADDR_IRQEN_DIVHI, 1'b1) |-> O_PRDATA[7:0] == hi_ff;
  endproperty
  a_div_hi: assert property (p_div_hi) else $error("divisor high readback");
  property p_ier_rd;
    s_rd(ADDR_IRQEN_DIVHI, 1'b0) |-> O_PRDATA[7:0] == ier_ff;
  endproperty
  a_ier_rd: assert property (p_ier_rd) else $error("enable readback");
  property p_ier_out;
    {O_PROG_TX_EMPTY_IRQ_MODE, O_LINE_STATUS_IRQ_EN, O_TX_EMPTY_IRQ_EN}
      == {ier_ff[IER_PROG_TX_EMPTY_BIT], ier_ff[IER_LINE_STAT_BIT], ier_ff[IER_TX_EMPTY_BIT]};
  endproperty
  a_ier_out: assert property (p_ier_out) else $error("enable outputs");
  property p_stop;
    {hi_ff, lo_ff} == 16'h0 |=> $stable(O_SERIAL_OUT) && $stable(O_IR_OUT_N);
  endproperty
  a_stop: assert property (p_stop) else $error("line moved, divisor zero");
  property p_ir_idle;
    !ir_ff |-> O_IR_OUT_N;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("infrared out outside mode");
endmodule : uart_dp_top_assertions
bind uart_dp_top uart_dp_top_assertions u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PSLVERR(O_PSLVERR), .O_SERIAL_OUT(O_SERIAL_OUT), .O_IR_OUT_N(O_IR_OUT_N),
  .O_LINE_STATUS_IRQ_EN(O_LINE_STATUS_IRQ_EN), .O_TX_EMPTY_IRQ_EN(O_TX_EMPTY_IRQ_EN),
  .O_PROG_TX_EMPTY_IRQ_MODE(O_PROG_TX_EMPTY_IRQ_MODE)
);
`default_nettype wire
